// ==== irq_word_three.sv ====
`timescale 1ns/1ps
`default_nettype none
module irq_word_three (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire irq_word_three_pkg::cpu_req_s cpu_req,
   input wire irq_word_three_pkg::event_s events,
   input wire logic other_words_irq,
   output logic [7:0] rdata_q,
   output logic [7:0] enable_q,
   output logic irq_q
);
   import irq_word_three_pkg::*;

   logic [2:0] status_rise;
   logic [7:0] gated;
   logic irq_d;

   function automatic logic word_hit(input logic [4:0] a);
      return a == ENABLE_WORD_THREE_ADDR;
   endfunction

   // ==========================================================
   // register port
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         enable_q <= ENABLE_WORD_THREE_RESET;
      end else if (cpu_req.wr_en && word_hit(cpu_req.addr)) begin
         enable_q <= cpu_req.wdata;
      end
   end

   // read data, zero for other addresses
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         rdata_q <= 8'h00;
      end else if (cpu_req.rd_en && word_hit(cpu_req.addr)) begin
         rdata_q <= enable_q;
      end else begin
         rdata_q <= 8'h00;
      end
   end

   // ==========================================================
   // edge detection of status flags
   rise_detect u_rise (
      .sys_clk(sys_clk),
      .nrst(nrst),
      .level({events.one_second_flag, events.five_second_flag, events.remote_alarm_crc_flag}),
      .rise(status_rise)
   );

   // source gating by the enable word
   always_comb begin
      gated = 8'h00;
      gated[FIRST_LINK_CTRL_IRQ_ENABLE] = events.link_ctrl_event[0] &
         enable_q[FIRST_LINK_CTRL_IRQ_ENABLE];
      gated[SECOND_LINK_CTRL_IRQ_ENABLE] = events.link_ctrl_event[1] &
         enable_q[SECOND_LINK_CTRL_IRQ_ENABLE];
      gated[THIRD_LINK_CTRL_IRQ_ENABLE] = events.link_ctrl_event[2] &
         enable_q[THIRD_LINK_CTRL_IRQ_ENABLE];
      gated[JITTER_FIFO_IRQ_ENABLE] = events.jitter_fifo_near_limit &
         enable_q[JITTER_FIFO_IRQ_ENABLE];
      gated[ONE_SECOND_IRQ_ENABLE] = status_rise[2] &
         enable_q[ONE_SECOND_IRQ_ENABLE];
      gated[FIVE_SECOND_IRQ_ENABLE] = status_rise[1] &
         enable_q[FIVE_SECOND_IRQ_ENABLE];
      gated[REMOTE_CRC_IRQ_ENABLE] = status_rise[0] &
         enable_q[REMOTE_CRC_IRQ_ENABLE];
      gated[SIGNALLING_CHANGE_IRQ_ENABLE] = events.signalling_change &
         enable_q[SIGNALLING_CHANGE_IRQ_ENABLE];
      irq_d = (|gated) | other_words_irq;
   end

   // registered interrupt request
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= irq_d;
      end
   end

   // ==========================================================
   // assertions, all on the system clock
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!nrst);

   // level sources other than the one under test are idle
   logic quiet;
   assign quiet = !other_words_irq && !events.jitter_fifo_near_limit &&
      !events.signalling_change && events.link_ctrl_event == 3'h0;

   // source levels laid out in enable bit order
   logic [7:0] src_level;
   assign src_level = {events.link_ctrl_event[0], events.link_ctrl_event[1],
      events.link_ctrl_event[2], events.jitter_fifo_near_limit, events.one_second_flag,
      events.five_second_flag, events.remote_alarm_crc_flag, events.signalling_change};

   // ==========================================================
   // link controllers, unmasked: request one cycle later
   first_ctrl_on_a: assert property (
      events.link_ctrl_event[0] && enable_q[7] |=> irq_q)
      else $error("first controller event lost");
   second_ctrl_on_a: assert property (
      events.link_ctrl_event[1] && enable_q[6] |=> irq_q)
      else $error("second controller event lost");
   third_ctrl_on_a: assert property (
      events.link_ctrl_event[2] && enable_q[5] |=> irq_q)
      else $error("third controller event lost");

   // ==========================================================
   // link controllers, masked while nothing else is active
   first_ctrl_off_a: assert property (
      src_level == 8'h80 && !enable_q[7] && !other_words_irq |=> !irq_q)
      else $error("masked first controller raised request");
   second_ctrl_off_a: assert property (
      src_level == 8'h40 && !enable_q[6] && !other_words_irq |=> !irq_q)
      else $error("masked second controller raised request");
   third_ctrl_off_a: assert property (
      src_level == 8'h20 && !enable_q[5] && !other_words_irq |=> !irq_q)
      else $error("masked third controller raised request");

   // ==========================================================
   // jitter fifo near its limit
   jitter_fifo_on_a: assert property (
      events.jitter_fifo_near_limit && enable_q[4] |=> irq_q)
      else $error("jitter fifo event lost");
   jitter_fifo_off_a: assert property (
      src_level == 8'h10 && !enable_q[4] && !other_words_irq |=> !irq_q)
      else $error("masked jitter fifo raised request");

   // ==========================================================
   // one second flag: only the rising edge counts
   one_sec_held_a: assert property (quiet && enable_q[3] && events.one_second_flag &&
      $past(events.one_second_flag) && !status_rise[1] && !status_rise[0] |=> !irq_q)
      else $error("held one second flag raised request");
   one_sec_rise_a: assert property (
      $rose(events.one_second_flag) && enable_q[3] |=> irq_q)
      else $error("one second edge lost");
   one_sec_fall_a: assert property (
      $fell(events.one_second_flag) && src_level == 8'h00 && !other_words_irq |=> !irq_q)
      else $error("falling one second flag raised request");
   one_sec_off_a: assert property (
      src_level == 8'h08 && !enable_q[3] && !other_words_irq |=> !irq_q)
      else $error("masked one second flag raised request");

   // ==========================================================
   // five second flag: only the rising edge counts
   five_sec_rise_a: assert property (
      $rose(events.five_second_flag) && enable_q[2] |=> irq_q)
      else $error("five second edge lost");
   five_sec_held_a: assert property (
      src_level == 8'h04 && $past(events.five_second_flag) && !other_words_irq |=> !irq_q)
      else $error("held five second flag raised request");
   five_sec_off_a: assert property (
      src_level == 8'h04 && !enable_q[2] && !other_words_irq |=> !irq_q)
      else $error("masked five second flag raised request");

   // ==========================================================
   // remote alarm and crc flag: only the rising edge counts
   remote_crc_rise_a: assert property (
      $rose(events.remote_alarm_crc_flag) && enable_q[1] |=> irq_q)
      else $error("remote alarm crc edge lost");
   remote_crc_held_a: assert property (
      src_level == 8'h02 && $past(events.remote_alarm_crc_flag) && !other_words_irq |=> !irq_q)
      else $error("held remote alarm crc flag raised request");
   remote_crc_off_a: assert property (
      src_level == 8'h02 && !enable_q[1] && !other_words_irq |=> !irq_q)
      else $error("masked remote alarm crc flag raised request");

   // ==========================================================
   // signalling change
   sig_change_on_a: assert property (
      events.signalling_change && enable_q[0] |=> irq_q)
      else $error("signalling change lost");
   sig_change_off_a: assert property (
      src_level == 8'h01 && !enable_q[0] && !other_words_irq |=> !irq_q)
      else $error("masked signalling change raised request");

   // ==========================================================
   // combined request: a request needs an open source one cycle back
   irq_or_a: assert property (irq_q |->
      $past(other_words_irq) ||
      $past(events.link_ctrl_event[0]) && $past(enable_q[7]) ||
      $past(events.link_ctrl_event[1]) && $past(enable_q[6]) ||
      $past(events.link_ctrl_event[2]) && $past(enable_q[5]) ||
      $past(events.jitter_fifo_near_limit) && $past(enable_q[4]) ||
      $past(events.signalling_change) && $past(enable_q[0]) ||
      $past(events.one_second_flag) && $past(enable_q[3]) &&
      !$past(events.one_second_flag, 2) ||
      $past(events.five_second_flag) && $past(enable_q[2]) &&
      !$past(events.five_second_flag, 2) ||
      $past(events.remote_alarm_crc_flag) && $past(enable_q[1]) &&
      !$past(events.remote_alarm_crc_flag, 2))
      else $error("request without an open source");
   other_words_a: assert property (
      other_words_irq |=> irq_q)
      else $error("other mask words not merged");
   irq_idle_a: assert property (
      src_level == 8'h00 && !other_words_irq |=> !irq_q)
      else $error("request with no source active");

   // ==========================================================
   // register port: write, hold and one-cycle read data
   enable_write_a: assert property (cpu_req.wr_en &&
      cpu_req.addr == ENABLE_WORD_THREE_ADDR |=> enable_q == $past(cpu_req.wdata))
      else $error("enable word write lost");
   enable_keep_a: assert property (!(cpu_req.wr_en &&
      cpu_req.addr == ENABLE_WORD_THREE_ADDR) |=> $stable(enable_q))
      else $error("enable word changed without a write");
   read_data_a: assert property (cpu_req.rd_en &&
      cpu_req.addr == ENABLE_WORD_THREE_ADDR |=> rdata_q == $past(enable_q))
      else $error("read data differs from enable word");
   read_idle_a: assert property (!(cpu_req.rd_en &&
      cpu_req.addr == ENABLE_WORD_THREE_ADDR) |=> rdata_q == 8'h00)
      else $error("read data not zero outside a read");

   // ==========================================================
   // main scenarios
   ctrl_irq_c: cover property (events.link_ctrl_event[0] && enable_q[7] ##1 irq_q);
   one_sec_irq_c: cover property ($rose(events.one_second_flag) && enable_q[3] ##1 irq_q);
   masked_c: cover property (src_level == 8'h01 && !enable_q[0] && !other_words_irq);
   fifo_irq_c: cover property (events.jitter_fifo_near_limit && enable_q[4] ##1 irq_q);
   other_words_c: cover property (other_words_irq ##1 irq_q);
endmodule // irq_word_three
`default_nettype wire

// ==== irq_word_three_pkg.sv ====
`default_nettype none
package irq_word_three_pkg;
   // ==========================================================
   // register map of the microprocessor port
   localparam logic [4:0] ENABLE_WORD_THREE_ADDR = 5'h1e;
   localparam logic [7:0] ENABLE_WORD_THREE_RESET = 8'h00;
   // ==========================================================
   // field positions inside the enable word
   localparam int FIRST_LINK_CTRL_IRQ_ENABLE = 7;
   localparam int SECOND_LINK_CTRL_IRQ_ENABLE = 6;
   localparam int THIRD_LINK_CTRL_IRQ_ENABLE = 5;
   localparam int JITTER_FIFO_IRQ_ENABLE = 4;
   localparam int ONE_SECOND_IRQ_ENABLE = 3;
   localparam int FIVE_SECOND_IRQ_ENABLE = 2;
   localparam int REMOTE_CRC_IRQ_ENABLE = 1;
   localparam int SIGNALLING_CHANGE_IRQ_ENABLE = 0;
   // ==========================================================
   // event sources seen by the block
   typedef struct packed {
      logic [2:0] link_ctrl_event;   // already unmasked inside each controller
      logic jitter_fifo_near_limit;  // within four bytes of over/underflow
      logic one_second_flag;
      logic five_second_flag;
      logic remote_alarm_crc_flag;
      logic signalling_change;       // any received abcd bit changed
   } event_s;
   // microprocessor port access
   typedef struct packed {
      logic wr_en;
      logic rd_en;
      logic [4:0] addr;
      logic [7:0] wdata;
   } cpu_req_s;
endpackage
`default_nettype wire

// ==== irq_word_three_test.sv ====
`timescale 1ns/1ps
`default_nettype none
module irq_word_three_test;
   import irq_word_three_pkg::*;
   logic sys_clk = 1'b0;
   logic nrst = 1'b0;
   cpu_req_s cpu_req = '0;
   event_s events = '0;
   logic other_words_irq = 1'b0;
   logic [7:0] rdata_q;
   logic [7:0] enable_q;
   logic irq_q;
   int mismatches = 0;
   int checks = 0;
   // ==========================================================
   // clock and design
   always #5 sys_clk = ~sys_clk;
   irq_word_three DUT (.sys_clk(sys_clk), .nrst(nrst), .cpu_req(cpu_req), .events(events),
      .other_words_irq(other_words_irq), .rdata_q(rdata_q), .enable_q(enable_q), .irq_q(irq_q));
   // ==========================================================
   // helpers: inputs change 1 ns after each rising edge
   task automatic tick;
      @(posedge sys_clk);
      #1;
   endtask
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic give_verdict;
      if (mismatches == 0 && checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic write_reg(input logic [4:0] a, input logic [7:0] d);
      cpu_req.addr = a;
      cpu_req.wdata = d;
      cpu_req.wr_en = 1'b1;
      tick;
      cpu_req.wr_en = 1'b0;
   endtask
   task automatic read_check(input logic [4:0] a, input logic [7:0] exp);
      cpu_req.addr = a;
      cpu_req.rd_en = 1'b1;
      tick;
      cpu_req.rd_en = 1'b0;
      check(rdata_q, exp);
   endtask
   // source bit in the event struct for enable bit i (link bits run reversed)
   function automatic logic [7:0] src_of(input int i);
      return 8'h01 << ((i < 5) ? i : 12 - i);
   endfunction
   // one source high for two cycles, irq checked in each, then quiet
   // edge sources (enable bits 1 to 3) open only the first cycle
   task automatic fire(input int i, input logic [7:0] en, input logic e1);
      write_reg(ENABLE_WORD_THREE_ADDR, en);
      events = src_of(i);
      tick;
      check({7'h00, irq_q}, {7'h00, e1});
      tick;
      check({7'h00, irq_q}, {7'h00, e1 && (i == 0 || i > 3)});
      events = '0;
      tick;
      tick;
   endtask
   // ==========================================================
   // watchdog
   initial begin
      #200000;
      mismatches++;
      give_verdict;
   end
   // ==========================================================
   // main sequence
   initial begin
      repeat (6) @(posedge sys_clk);
      #1;
      nrst = 1'b1;
      check(enable_q, ENABLE_WORD_THREE_RESET);
      check({7'h00, irq_q}, 8'h00);
      read_check(ENABLE_WORD_THREE_ADDR, ENABLE_WORD_THREE_RESET);
      write_reg(ENABLE_WORD_THREE_ADDR, 8'ha5);
      read_check(ENABLE_WORD_THREE_ADDR, 8'ha5);
      tick;
      check(rdata_q, 8'h00);
      write_reg(5'h1d, 8'h3c);
      check(enable_q, 8'ha5);
      read_check(5'h1d, 8'h00);
      // each source unmasked, then masked with all others open
      for (int i = 0; i < 8; i++) begin
         fire(i, 8'h01 << i, 1'b1);
         fire(i, ~(8'h01 << i), 1'b0);
      end
      // other mask words pass straight through
      write_reg(ENABLE_WORD_THREE_ADDR, 8'h00);
      other_words_irq = 1'b1;
      tick;
      check({7'h00, irq_q}, 8'h01);
      other_words_irq = 1'b0;
      tick;
      check({7'h00, irq_q}, 8'h00);
      give_verdict;
   end
endmodule // irq_word_three_test
`default_nettype wire

// ==== rise_detect.sv ====
`timescale 1ns/1ps
`default_nettype none
module rise_detect (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic [2:0] level,
   output logic [2:0] rise
);
   logic [2:0] level_q;

   // ==========================================================
   // previous level of each status flag
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         level_q <= 3'h0;
      end else begin
         level_q <= level;
      end
   end

   // zero to one transition only
   assign rise = level & ~level_q;
endmodule // rise_detect
`default_nettype wire
